// ---- i2sirq_top.v ----
/*
 Event aggregation with sticky status, enable, force and masked view onto one
 interrupt line, plus transmit and receive word-select watchdogs on core_clk.
 Assumes a classic Wishbone master, word selects from an external master pin,
 and FIFO event pulses from logic on the same clock.
*/
`timescale 1ns/10ps
`include "i2sirq_defines.vh"

module i2sirq_top #(
   parameter AW = 8
) (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [AW-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg wb_err_o,
   // FIFO event pulses, bit layout as the status register
   input wire [31:0] fifo_event,
   // Word select pins from the external master
   input wire transmit_word_select_in,
   input wire receive_word_select_in,
   // Interrupt to the CPU interrupt controller
   output reg irq
);

   reg [31:0] event_status_reg;
   reg [31:0] event_enable_reg;
   reg [31:0] transmit_control_reg;
   reg [31:0] receive_control_reg;
   reg [31:0] transmit_watchdog_reload;
   reg [31:0] receive_watchdog_reload;
   reg [31:0] tx_count;
   reg [31:0] rx_count;
   reg [2:0] transmit_word_select_in_sync;
   reg [2:0] receive_word_select_in_sync;
   reg transmit_word_select_in_level;
   reg receive_word_select_in_level;
   reg transmit_watchdog_event;
   reg receive_watchdog_event;

   wire [31:0] enabled_pending_reg;
   wire req;
   wire wr;
   wire rd;
   wire [31:0] byte_mask;
   wire [31:0] clr_bits;
   wire [31:0] force_bits;
   wire [31:0] hw_set;
   wire tx_run;
   wire rx_run;
   wire tx_rise;
   wire rx_rise;
   reg known;
   reg [31:0] rd_data;

   // Byte lane write mask from the select lines
   function [31:0] lane_mask;
      input [3:0] sel;
      begin
         lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      end
   endfunction

   // Merge of a byte-masked write into a stored value
   function [31:0] merge;
      input [31:0] old;
      input [31:0] din;
      input [31:0] bm;
      input [31:0] keep;
      begin
         merge = ((old & ~bm) | (din & bm)) & keep;
      end
   endfunction

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign wr = req & wb_we_i & known;
   assign rd = req & ~wb_we_i & known;
   assign byte_mask = lane_mask(wb_sel_i);

   assign enabled_pending_reg = event_status_reg & event_enable_reg;

   // Clearing takes effect with the write itself; the dummy read is harmless
   assign clr_bits = (wr && wb_adr_i == `I2SIRQ_OFS_STATUS) ? (wb_dat_i & byte_mask) : 32'h0;
   assign force_bits = (wr && wb_adr_i == `I2SIRQ_OFS_FORCE) ? (wb_dat_i & byte_mask) : 32'h0;

   // Watchdog bits come only from the counters, never from the FIFO event bus
   assign hw_set = (fifo_event & `I2SIRQ_EV_FIFO_MASK)
                 | ({31'h0, transmit_watchdog_event} << `I2SIRQ_EV_TRANSMIT_WATCHDOG_EVENT)
                 | ({31'h0, receive_watchdog_event} << `I2SIRQ_EV_RECEIVE_WATCHDOG_EVENT);

   always @* begin
      known = 1'b1;
      rd_data = 32'h0;
      case (wb_adr_i)
         `I2SIRQ_OFS_STATUS: rd_data = event_status_reg;
         `I2SIRQ_OFS_FORCE: rd_data = event_status_reg;
         `I2SIRQ_OFS_ENABLE: rd_data = event_enable_reg;
         `I2SIRQ_OFS_PENDING: rd_data = enabled_pending_reg;
         `I2SIRQ_OFS_TX_CTL: rd_data = transmit_control_reg;
         `I2SIRQ_OFS_RX_CTL: rd_data = receive_control_reg;
         `I2SIRQ_OFS_TX_WDOG: rd_data = transmit_watchdog_reload;
         `I2SIRQ_OFS_RX_WDOG: rd_data = receive_watchdog_reload;
         default: known = 1'b0;
      endcase
   end

   // Bus answer: one cycle after the request, ack or err for unmapped
   always @(posedge core_clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req & known;
         wb_err_o <= req & ~known;
         if (rd) begin
            wb_dat_o <= rd_data;
         end else begin
            wb_dat_o <= 32'h0;
         end
      end
   end

   // Writable registers
   always @(posedge core_clk) begin
      if (srst) begin
         event_enable_reg <= `I2SIRQ_RST_EV;
         transmit_control_reg <= `I2SIRQ_RST_CTL;
         receive_control_reg <= `I2SIRQ_RST_CTL;
         transmit_watchdog_reload <= `I2SIRQ_RST_WDOG;
         receive_watchdog_reload <= `I2SIRQ_RST_WDOG;
      end else if (wr) begin
         case (wb_adr_i)
            `I2SIRQ_OFS_ENABLE: event_enable_reg <=
               merge(event_enable_reg, wb_dat_i, byte_mask, `I2SIRQ_EV_MASK);
            `I2SIRQ_OFS_TX_CTL: transmit_control_reg <=
               merge(transmit_control_reg, wb_dat_i, byte_mask, `I2SIRQ_CTL_MASK);
            `I2SIRQ_OFS_RX_CTL: receive_control_reg <=
               merge(receive_control_reg, wb_dat_i, byte_mask, `I2SIRQ_CTL_MASK);
            `I2SIRQ_OFS_TX_WDOG: transmit_watchdog_reload <=
               merge(transmit_watchdog_reload, wb_dat_i, byte_mask, 32'hffffffff);
            `I2SIRQ_OFS_RX_WDOG: receive_watchdog_reload <=
               merge(receive_watchdog_reload, wb_dat_i, byte_mask, 32'hffffffff);
            default: ;
         endcase
      end
   end

   // Sticky status: hardware and force sets win over a same-cycle clear
   always @(posedge core_clk) begin
      if (srst) begin
         event_status_reg <= `I2SIRQ_RST_EV;
      end else begin
         event_status_reg <= ((event_status_reg & ~clr_bits) | hw_set | force_bits)
                             & `I2SIRQ_EV_MASK;
      end
   end

   // Single combined interrupt line
   always @(posedge core_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |enabled_pending_reg;
      end
   end

   // Word select pins: three stages, a level change counts once stages two and three agree
   always @(posedge core_clk) begin
      if (srst) begin
         transmit_word_select_in_sync <= 3'h0;
         receive_word_select_in_sync <= 3'h0;
         transmit_word_select_in_level <= 1'b0;
         receive_word_select_in_level <= 1'b0;
      end else begin
         transmit_word_select_in_sync <= {transmit_word_select_in_sync[1:0], transmit_word_select_in};
         receive_word_select_in_sync <= {receive_word_select_in_sync[1:0], receive_word_select_in};
         if (transmit_word_select_in_sync[2] == transmit_word_select_in_sync[1]) begin
            transmit_word_select_in_level <= transmit_word_select_in_sync[2];
         end
         if (receive_word_select_in_sync[2] == receive_word_select_in_sync[1]) begin
            receive_word_select_in_level <= receive_word_select_in_sync[2];
         end
      end
   end

   assign tx_rise = transmit_word_select_in_sync[2] & transmit_word_select_in_sync[1] & ~transmit_word_select_in_level;
   assign rx_rise = receive_word_select_in_sync[2] & receive_word_select_in_sync[1] & ~receive_word_select_in_level;

   // Run only in slave mode, with enable, start and a non-zero reload
   assign tx_run = transmit_control_reg[`I2SIRQ_CTL_WATCHDOG_ENABLE_BIT] & transmit_control_reg[`I2SIRQ_CTL_START]
                 & transmit_control_reg[`I2SIRQ_CTL_SLAVE] & (|transmit_watchdog_reload);
   assign rx_run = receive_control_reg[`I2SIRQ_CTL_WATCHDOG_ENABLE_BIT] & receive_control_reg[`I2SIRQ_CTL_START]
                 & receive_control_reg[`I2SIRQ_CTL_SLAVE] & (|receive_watchdog_reload);

   // Watchdogs on the peripheral clock; an idle counter holds the reload value
   always @(posedge core_clk) begin
      if (srst) begin
         tx_count <= `I2SIRQ_RST_WDOG;
         rx_count <= `I2SIRQ_RST_WDOG;
         transmit_watchdog_event <= 1'b0;
         receive_watchdog_event <= 1'b0;
      end else begin
         transmit_watchdog_event <= 1'b0;
         receive_watchdog_event <= 1'b0;
         if (!tx_run || tx_rise) begin
            tx_count <= transmit_watchdog_reload;
         end else if (tx_count == 32'h0) begin
            tx_count <= transmit_watchdog_reload;
         end else begin
            tx_count <= tx_count - 32'h1;
            transmit_watchdog_event <= (tx_count == 32'h1);
         end
         if (!rx_run || rx_rise) begin
            rx_count <= receive_watchdog_reload;
         end else if (rx_count == 32'h0) begin
            rx_count <= receive_watchdog_reload;
         end else begin
            rx_count <= rx_count - 32'h1;
            receive_watchdog_event <= (rx_count == 32'h1);
         end
      end
   end

endmodule // i2sirq_top

// ---- i2sirq_defines.vh ----
/*
 Register offsets, field positions, reset values and event bit positions for the
 audio serial event/interrupt block with its transmit and receive word-select watchdogs.
 Assumes a classic Wishbone slave with 32-bit data, one aligned word per register.
*/
// How it works
// - One interrupt output line carries the combined request of all events.
// - Twelve events: tx trigger/notfull/empty/ovf/unf/wd, rx trigger/notempty/full/ovf/unf/wd.
// - Each event has an enable bit; writing one enables it onto the line.
// - Hardware sets an event's status bit whenever it occurs, enabled or not.
// - Enabled-pending register reads status AND enable, bit by bit.
// - Interrupt line is the OR of all enabled-pending bits.
// - Writing one to a force bit sets the matching status bit.
// - Status bits are sticky, cleared only by writing one to them.
// - Separate transmit and receive watchdogs raise events on idle word select.
// - Watchdogs operate only in slave mode with external word select.
// - Each watchdog has an enable bit and a 32-bit reload register.
// - A zero reload value disables the watchdog even when enabled.
// - Watchdog counters run on the peripheral system clock.
// - A watchdog counts only when its enable and start bits are set.
// - Counter reloads on word-select rising edge and when it reaches zero.
// - Count reaching zero sets that direction's watchdog status bit.
`ifndef I2SIRQ_DEFINES_VH
`define I2SIRQ_DEFINES_VH

// Byte addresses
`define I2SIRQ_OFS_STATUS 8'h00
`define I2SIRQ_OFS_FORCE 8'h04
`define I2SIRQ_OFS_ENABLE 8'h08
`define I2SIRQ_OFS_PENDING 8'h0c
`define I2SIRQ_OFS_TX_CTL 8'h10
`define I2SIRQ_OFS_RX_CTL 8'h14
`define I2SIRQ_OFS_TX_WDOG 8'h18
`define I2SIRQ_OFS_RX_WDOG 8'h1c

// Event bit positions
`define I2SIRQ_EV_TX_TRIGGER 0
`define I2SIRQ_EV_TX_NOT_FULL 1
`define I2SIRQ_EV_TX_EMPTY 2
`define I2SIRQ_EV_TX_OVERFLOW 3
`define I2SIRQ_EV_TX_UNDERFLOW 4
`define I2SIRQ_EV_TRANSMIT_WATCHDOG_EVENT 5
`define I2SIRQ_EV_RX_TRIGGER 8
`define I2SIRQ_EV_RX_NOT_EMPTY 9
`define I2SIRQ_EV_RX_FULL 10
`define I2SIRQ_EV_RX_OVERFLOW 11
`define I2SIRQ_EV_RX_UNDERFLOW 12
`define I2SIRQ_EV_RECEIVE_WATCHDOG_EVENT 13
`define I2SIRQ_EV_MASK 32'h00003f3f
`define I2SIRQ_EV_FIFO_MASK 32'h00001f1f

// Direction control fields
`define I2SIRQ_CTL_WATCHDOG_ENABLE_BIT 0
`define I2SIRQ_CTL_START 1
`define I2SIRQ_CTL_SLAVE 2
`define I2SIRQ_CTL_MASK 32'h00000007

// Reset values
`define I2SIRQ_RST_CTL 32'h00000000
`define I2SIRQ_RST_WDOG 32'h00000000
`define I2SIRQ_RST_EV 32'h00000000

`endif

// ---- i2sirq_monitor.sv ----
/* Port checker for the event/interrupt block with its word-select watchdogs.
 Assumes a classic Wishbone master and a synchronous active-high reset. */
`timescale 1ns/10ps
module i2sirq_monitor #(parameter AW = 8) (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Register bus
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [AW-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire wb_err_o,
   // Events, word selects, interrupt
   input wire [31:0] fifo_event,
   input wire transmit_word_select_in,
   input wire receive_word_select_in,
   input wire irq
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (srst);
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire mapped = wb_adr_i <= 8'h1c && wb_adr_i[1:0] == 2'h0;
   a_one_answer: assert property (take |=> wb_ack_o != wb_err_o)
      else $error("bus request without a single answer");
   a_answer_pulse: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
      else $error("answer held past one cycle");
   a_err_unmapped: assert property (take && !mapped |=> wb_err_o)
      else $error("unmapped access not refused");
   a_ack_mapped: assert property (take && mapped |=> wb_ack_o)
      else $error("mapped access not acknowledged");
   a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside an answer");
   a_irq_sticky: assert property ($fell(irq) |-> $past(wb_ack_o && wb_we_i))
      else $error("interrupt dropped without a write");
   a_irq_pending: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h0c |-> irq == (wb_dat_o != 32'h0))
      else $error("interrupt disagrees with pending view");
   a_reset_quiet: assert property ($fell(srst) |-> !irq && !wb_ack_o && !wb_err_o)
      else $error("outputs active after reset");
   c_refused: cover property (wb_err_o);
   c_irq_rise: cover property ($rose(irq));
   c_irq_fall: cover property ($fell(irq));
endmodule // i2sirq_monitor

// ---- i2sirq_ws_master.sv ----
/* External word-select master feeding both direction inputs.
 Assumes the bench sets the half period in clocks; zero holds the line still. */
`timescale 1ns/10ps
module i2sirq_ws_master (
   // Clock and control
   input wire core_clk,
   input wire [7:0] half,
   // Word select, one line shared by both directions
   output logic ws
);
   logic [7:0] cnt = 8'h0;
   initial ws = 1'b0;
   // Only the master moves the line, and only just after an edge
   always @(posedge core_clk) begin
      cnt <= (cnt + 8'h1 >= half) ? 8'h0 : cnt + 8'h1;
      if (half != 8'h0 && cnt + 8'h1 >= half)
         ws <= !ws;
   end
endmodule // i2sirq_ws_master

// ---- test_i2s_event_irq_and_ws_watchdog.sv ----
/* Self-checking bench for the event/interrupt block and its watchdogs.
 Assumes the monitor and the word-select master are compiled first. */
`timescale 1ns/10ps
module test_i2s_event_irq_and_ws_watchdog;
   logic core_clk, srst, cyc, stb, wen, ack, err, irq, ws, err_seen;
   logic [7:0] adr, half;
   logic [3:0] sel;
   logic [31:0] wdat, dat_o, ev, q;
   int n_mismatch, checked, cycles;
   typedef struct packed {logic [31:0] ev, en, st, pend;} i2sirq_row_t;
   // Bits 5, 13 and the upper half of the event bus are not FIFO events
   i2sirq_row_t rows [5] = '{'{32'h3f3f, 32'h0, 32'h1f1f, 32'h0},
      '{32'h1, 32'hffffffff, 32'h1, 32'h1}, '{32'h1f00, 32'h100, 32'h1f00, 32'h100},
      '{32'hffffc0c0, 32'h12, 32'h0, 32'h0}, '{32'h12, 32'h2, 32'h12, 32'h2}};
   i2sirq_top i2sirq_top_inst (.core_clk(core_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .wb_err_o(err), .fifo_event(ev), .transmit_word_select_in(ws),
      .receive_word_select_in(ws), .irq(irq));
   i2sirq_ws_master i2sirq_ws_master_inst (.core_clk(core_clk), .half(half), .ws(ws));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      wen <= we;
      adr <= a;
      wdat <= d;
      do @(posedge core_clk); while (ack !== 1'b1 && err !== 1'b1);
      q = dat_o;
      err_seen = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic pulse(input logic [31:0] e);
      @(posedge core_clk);
      ev <= e;
      @(posedge core_clk);
      ev <= 32'h0;
   endtask
   // Long enough for several expiries at reload 10, never reached between ws rising edges 8 apart
   task automatic wd(input logic [7:0] ctl_ofs, input logic [31:0] ctl, input logic [31:0] rl,
         input logic [7:0] h, input logic [31:0] exp);
      half <= h;
      wb(1'b1, 8'h00, 32'h3f3f);
      wb(1'b1, ctl_ofs + 8'h8, rl);
      wb(1'b1, ctl_ofs, ctl);
      repeat (60) @(posedge core_clk);
      wb(1'b1, ctl_ofs, 32'h0);
      wb(1'b0, 8'h00, 32'h0);
      chk(q & 32'h2020, exp);
   endtask
   task automatic complete_run;
      $display("%0d mismatches in %0d checks", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      {srst, cyc, stb, wen, adr, wdat, ev, half, sel} = {1'b1, 83'h0, 4'hf};
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      foreach (rows[i]) begin
         wb(1'b1, 8'h08, rows[i].en);
         wb(1'b0, 8'h08, 32'h0);
         chk(q, rows[i].en & 32'h3f3f);
         pulse(rows[i].ev);
         wb(1'b0, 8'h00, 32'h0);
         chk(q, rows[i].st);
         wb(1'b0, 8'h0c, 32'h0);
         chk(q, rows[i].pend);
         chk({31'h0, irq}, {31'h0, rows[i].pend != 32'h0});
         wb(1'b1, 8'h00, rows[i].st);
         $display("row %0d done", i);
      end
      wb(1'b1, 8'h08, 32'h2021);
      wb(1'b1, 8'h04, 32'h2121);
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h2121);
      wb(1'b1, 8'h00, 32'h1);
      wb(1'b0, 8'h0c, 32'h0);
      chk(q, 32'h2020);
      chk({31'h0, irq}, 32'h1);
      wb(1'b1, 8'h00, q);
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h100);
      chk({31'h0, irq}, 32'h0);
      $display("force and clear done");
      wb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err_seen}, 32'h1);
      wb(1'b1, 8'h0c, 32'hffffffff);
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h100);
      $display("refusals done");
      wd(8'h10, 32'h7, 32'd10, 8'h0, 32'h20);
      wd(8'h10, 32'h7, 32'd10, 8'h4, 32'h0);
      wd(8'h10, 32'h7, 32'h0, 8'h0, 32'h0);
      wd(8'h10, 32'h5, 32'd10, 8'h0, 32'h0);
      wd(8'h10, 32'h3, 32'd10, 8'h0, 32'h0);
      wd(8'h14, 32'h7, 32'd10, 8'h0, 32'h2000);
      $display("watchdogs done");
      chk({31'h0, irq}, 32'h1);
      srst <= 1'b1;
      repeat (3) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      wb(1'b0, 8'h08, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0);
      $display("reset done");
      complete_run();
   end
endmodule // test_i2s_event_irq_and_ws_watchdog
bind i2sirq_top i2sirq_monitor #(.AW(AW)) i2sirq_monitor_inst (.core_clk(core_clk), .srst(srst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .fifo_event(fifo_event), .transmit_word_select_in(transmit_word_select_in),
   .receive_word_select_in(receive_word_select_in), .irq(irq));
